/* File: padc_consts.vh */
// Purpose: Shared constants for the pipelined sample capture block.
// Assumes: A 25 MHz system clock.
// Notes:   Times are kept in ns and turned into clock counts here.
`ifndef PADC_CONSTS_VH
`define PADC_CONSTS_VH

// ----------------------------------------------------------------------
// Word format
// ----------------------------------------------------------------------
`define PADC_WORD_W          10
`define PADC_SIGN_BIT        9
`define PADC_RESET_WORD      10'h000

// ----------------------------------------------------------------------
// Pipeline and timing
// ----------------------------------------------------------------------
`define PADC_PIPE_STROBES    3
`define PADC_CLK_PERIOD_NS   40
`define PADC_VALID_DELAY_NS  200
`define PADC_VALID_DELAY_CYC \
  ((`PADC_VALID_DELAY_NS + `PADC_CLK_PERIOD_NS - 1) / `PADC_CLK_PERIOD_NS)
// Clocks that a strobe needs from its pin to the FIFO push, sampling slack included.
`define PADC_SYNC_CYC        3
`define PADC_FIFO_DEPTH      8
`define PADC_FIFO_AW         3

`endif

/* File: padc_fifo.v */
// Purpose: Small synchronous FIFO holding samples still inside the pipeline.
// Assumes: Single clock; DEPTH is a power of two equal to 2**AW.
// Notes:   Read data comes from a register and shows the head word.
`timescale 1ns/1ps
`default_nettype none
`include "padc_consts.vh"

module padc_fifo
#(
  parameter WIDTH = `PADC_WORD_W,
  parameter DEPTH = `PADC_FIFO_DEPTH,
  parameter AW    = `PADC_FIFO_AW
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_r,
  output reg  [AW:0]      level_r
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_r;
  reg  [AW-1:0]    rd_ptr_r;
  wire             push;
  wire             pop;
  wire [AW-1:0]    rd_ptr_nxt;

  assign in_ready   = (level_r != DEPTH[AW:0]);
  assign out_valid  = (level_r != {(AW+1){1'b0}});
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign rd_ptr_nxt = pop ? rd_ptr_r + {{(AW-1){1'b0}}, 1'b1} : rd_ptr_r;

  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // ----------------------------------------------------------------------
  // Pointers, level and registered head word
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_r   <= {AW{1'b0}};
      rd_ptr_r   <= {AW{1'b0}};
      level_r    <= {(AW+1){1'b0}};
      out_data_r <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      rd_ptr_r <= rd_ptr_nxt;
      if (push && !pop)
      begin
        level_r <= level_r + {{AW{1'b0}}, 1'b1};
      end
      else if (pop && !push)
      begin
        level_r <= level_r - {{AW{1'b0}}, 1'b1};
      end
      // The word being written is not in memory yet, so it bypasses to the head.
      if (push && (wr_ptr_r == rd_ptr_nxt))
      begin
        out_data_r <= in_data;
      end
      else
      begin
        out_data_r <= mem[rd_ptr_nxt];
      end
    end
  end

endmodule // padc_fifo

`default_nettype wire

/* File: padc_capture.v */
// Purpose: Digital side of a 10-bit pipelined converter driven by a sample strobe.
// Assumes: Strobe and quantizer code arrive asynchronously to clk at 25 MHz.
// Notes:   There is no data-ready output; the strobe sequence implies timing.
`timescale 1ns/1ps
`default_nettype none
`include "padc_consts.vh"

// Contract
// - A sample reaches the outputs only after three strobes, its own plus two more.
// - A word is valid two strobe periods plus 200 ns after the strobe that took it.
// - Each result is a 10-bit parallel NRZ word whose bits all change together.
// - Words are two's complement, 0111111111 at full scale, 0 and all ones around zero.
// - No data-ready or valid signal accompanies the output word.
// - Positive full scale gives the largest positive code and coding stays two's complement.
module padc_capture
#(
  parameter WORD_W    = `PADC_WORD_W,
  parameter PIPE      = `PADC_PIPE_STROBES,
  parameter DELAY_CYC = `PADC_VALID_DELAY_CYC,
  parameter FIFO_D    = `PADC_FIFO_DEPTH,
  parameter FIFO_AW   = `PADC_FIFO_AW
)
(
  input  wire              clk,
  input  wire              reset,
  input  wire              sample_strobe,
  input  wire [WORD_W-1:0] quant_code,
  output reg  [WORD_W-1:0] data_out_r,
  output reg               overrun_r
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // The quantizer counts upward from negative full scale; flipping the top
  // bit turns that count into two's complement, so all ones maps to 0x1ff.
  function [WORD_W-1:0] to_twos_complement_coding;
    input [WORD_W-1:0] offset_code;
    begin
      to_twos_complement_coding = offset_code ^ {1'b1, {(WORD_W-1){1'b0}}};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // A strobe shorter than one clock period can slip between edges; the
  // shortest legal strobe is below 40 ns, so the far end must keep it wider.
  reg              strobe_s1_r;
  reg              strobe_s2_r;
  reg              strobe_d_r;
  reg [WORD_W-1:0] code_s1_r;
  reg [WORD_W-1:0] code_s2_r;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strobe_s1_r <= 1'b0;
      strobe_s2_r <= 1'b0;
      strobe_d_r  <= 1'b0;
      code_s1_r   <= {WORD_W{1'b0}};
      code_s2_r   <= {WORD_W{1'b0}};
    end
    else
    begin
      strobe_s1_r <= sample_strobe;
      strobe_s2_r <= strobe_s1_r;
      strobe_d_r  <= strobe_s2_r;
      code_s1_r   <= quant_code;
      code_s2_r   <= code_s1_r;
    end
  end

  // Each leading edge starts one conversion if the synchroniser sampled the strobe low on the clock before.
  wire strobe_edge;
  assign strobe_edge = strobe_s2_r & ~strobe_d_r;

  // ----------------------------------------------------------------------
  // Sample pipeline
  // ----------------------------------------------------------------------
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire [WORD_W-1:0] fifo_head;
  wire [FIFO_AW:0]  fifo_level;
  wire              take;
  wire              release_pulse;
  reg  [7:0]        delay_cnt_r;

  assign take = strobe_edge & fifo_in_ready;

  padc_fifo
  #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_D),
    .AW    (FIFO_AW)
  )
  i_padc_fifo
  (
    .clk        (clk),
    .reset      (reset),
    .in_valid   (strobe_edge),
    .in_ready   (fifo_in_ready),
    .in_data    (code_s2_r),
    .out_valid  (fifo_out_valid),
    .out_ready  (release_pulse),
    .out_data_r (fifo_head),
    .level_r    (fifo_level)
  );

  // The oldest sample leaves only on the second strobe after the one that took it.
  wire arm;
  assign arm = take & (fifo_level >= PIPE[FIFO_AW:0] - {{FIFO_AW{1'b0}}, 1'b1});

  // The pin-to-push path already spends up to three clocks of the 200 ns budget,
  // so the timer only counts what is left; counting the full delay from the push
  // would bring the word out late.
  localparam LOAD_CYC = (DELAY_CYC > `PADC_SYNC_CYC) ? DELAY_CYC - `PADC_SYNC_CYC : 1;

  // The release waits the remaining delay after the strobe that shifts it out.
  assign release_pulse = (delay_cnt_r == 8'h01) & fifo_out_valid;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      delay_cnt_r <= 8'h00;
    end
    else if (arm)
    begin
      delay_cnt_r <= LOAD_CYC[7:0];
    end
    else if (delay_cnt_r != 8'h00)
    begin
      delay_cnt_r <= delay_cnt_r - 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Output word
  // ----------------------------------------------------------------------
  // One register loads all bits on one edge, so the word changes as a whole
  // and then holds until the next release; nothing flags its arrival.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      data_out_r <= `PADC_RESET_WORD;
      overrun_r  <= 1'b0;
    end
    else
    begin
      if (release_pulse)
      begin
        data_out_r <= to_twos_complement_coding(fifo_head);
      end
      if (strobe_edge && !fifo_in_ready)
      begin
        overrun_r <= 1'b1;
      end
    end
  end

  // No ready or valid output exists; timing follows the strobes alone.

endmodule // padc_capture

`default_nettype wire

/* File: padc_capture_asserts.sv */
// Purpose: Port checks for the sample capture block.
// Assumes: DELAY_CYC of 5, so a word moves 5 clocks after a strobe rise.
// Notes:   Helper logic logs the strobe history.
`timescale 1ns/1ps
`default_nettype none
module padc_capture_asserts (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       sample_strobe,
  input wire logic [9:0] quant_code,
  input wire logic [9:0] data_out_r,
  input wire logic       overrun_r
);
  logic [8:0] sh_r;
  logic [1:0] cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always @(posedge clk or posedge reset)
    if (reset)
    begin
      sh_r  <= 9'h000;
      cnt_r <= 2'h0;
    end
    else
    begin
      sh_r <= {sh_r[7:0], sample_strobe};
      if (sample_strobe && !sh_r[0] && cnt_r != 2'h3)
        cnt_r <= cnt_r + 2'h1;
    end
  property p_lat; $changed(data_out_r) |-> sh_r[4] && !sh_r[5]; endproperty
  a_lat: assert property (p_lat) else $error("word moved off strobe timing");
  property p_fill; $changed(data_out_r) |-> cnt_r == 2'h3; endproperty
  a_fill: assert property (p_fill) else $error("word before pipe filled");
  property p_hold; $changed(data_out_r) |=> $stable(data_out_r) [*4]; endproperty
  a_hold: assert property (p_hold) else $error("word did not hold");
  property p_zero; $fell(reset) |-> data_out_r == 10'h000; endproperty
  a_zero: assert property (p_zero) else $error("word not zero after reset");
  property p_quiet; sh_r == 9'h000 |-> $stable(data_out_r); endproperty
  a_quiet: assert property (p_quiet) else $error("word moved without strobe");
  property p_ovr; !overrun_r; endproperty
  a_ovr: assert property (p_ovr) else $error("strobe dropped");
  c_first: cover property (cnt_r == 2'h3 && $changed(data_out_r));
  c_rst: cover property ($fell(reset));
  c_fs: cover property (data_out_r == 10'h1ff);
endmodule // padc_capture_asserts
bind padc_capture padc_capture_asserts i_padc_capture_asserts (.clk(clk), .reset(reset),
  .sample_strobe(sample_strobe), .quant_code(quant_code), .data_out_r(data_out_r),
  .overrun_r(overrun_r));
`default_nettype wire

/* File: padc_host.sv */
// Purpose: Controller model that strobes the converter and latches words.
// Assumes: Driven at the falling clock edge; go is a one-cycle request.
// Notes:   Code is inverted after the strobe so late sampling shows.
`timescale 1ns/1ps
`default_nettype none
module padc_host (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic [9:0] code,
  input  wire logic [9:0] dout,
  output logic            strobe,
  output logic [9:0]      qc,
  output logic            cap_v,
  output logic [9:0]      cap
);
  int n;
  initial {strobe, qc, cap_v, cap, n} = '0;
  always @(negedge clk)
    if (reset)
      n = 0;
    else if (go)
    begin
      qc <= code;
      @(negedge clk) strobe <= 1'b1;
      repeat (2) @(negedge clk);
      strobe <= 1'b0;
      cap <= dout;
      cap_v <= n >= 3;
      n++;
      qc <= ~code;
      @(negedge clk) cap_v <= 1'b0;
    end
endmodule // padc_host
`default_nettype wire

/* File: pipelined_adc_sample_capture_tb.sv */
// Purpose: Self-checking bench for the sample capture block.
// Assumes: Strobes at least 6 clocks apart, below the 5 MHz limit.
// Notes:   Each strobe queues the word the trailing latch three strobes later should see.
`timescale 1ns/1ps
`default_nettype none
module pipelined_adc_sample_capture_tb;
  logic clk = 0, reset = 1, go = 0, strobe, cap_v, ovr;
  logic [9:0] code = 10'h000, cap, dout, qc;
  logic [9:0] q[$];
  logic [9:0] fs[4] = '{10'h3ff, 10'h200, 10'h1ff, 10'h000};
  int err_total = 0, comparisons = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  padc_capture i_padc_capture (.clk(clk), .reset(reset), .sample_strobe(strobe),
    .quant_code(qc), .data_out_r(dout), .overrun_r(ovr));
  padc_host i_padc_host (.clk(clk), .reset(reset), .go(go), .code(code), .dout(dout),
    .strobe(strobe), .qc(qc), .cap_v(cap_v), .cap(cap));
  task chk(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task stb(input logic [9:0] c, input int gap);
    code <= c;
    go <= 1'b1;
    q.push_back({~c[9], c[8:0]});
    @(negedge clk) go <= 1'b0;
    repeat (gap) @(negedge clk);
  endtask
  always @(negedge clk)
    if (cap_v === 1'b1)
      chk(cap, q.pop_front());
  always @(posedge clk)
    if (++cyc == 20000)
    begin
      err_total++;
      tally_and_finish;
    end
  initial
  begin
    void'($urandom(32'hedb5));
    repeat (12) @(negedge clk);
    reset <= 1'b0;
    @(negedge clk);
    foreach (fs[i]) stb(fs[i], 5);
    repeat (20) stb(10'($urandom), 5 + $urandom % 4);
    reset <= 1'b1;
    q.delete();
    repeat (3) @(negedge clk);
    reset <= 1'b0;
    @(negedge clk);
    stb(10'h155, 5);
    stb(10'h0aa, 5);
    repeat (5) @(negedge clk);
    chk(dout, 10'h000);
    stb(10'h2aa, 9);
    chk(dout, 10'h355);
    repeat (3) stb(10'h000, 5);
    chk({9'h000, ovr}, 10'h000);
    chk(10'(q.size()), 10'h003);
    tally_and_finish;
  end
endmodule // pipelined_adc_sample_capture_tb
`default_nettype wire
